// *** rtl/eep_pkg.sv ***
// Notes on behaviour
// RQ1 - array holds 256 bytes, byte addressed
// RQ2 - lower half protectable, reversibly or permanently
// RQ3 - type 1010 memory, 0110 protection settings
// RQ4 - select bits b3..b1 must match straps
// RQ5 - unconnected straps read as zero
// RQ6 - lowest strap high voltage qualifies set/clear
// RQ7 - set/clear codes need matching strap levels
// RQ8 - lock compares straps, direction 0 lock
// RQ9 - select byte shifted in msb first
// RQ10 - write protect input blocks all writes
// RQ11 - protect input low: stored state decides
// RQ12 - ack in ninth slot of each byte
// RQ13 - master ends writes after ack, reads after nack
// RQ14 - ignore bus until power-on reset releases
// RQ15 - supply loss stops all responses at once
// RQ16 - data line open drain only
// RQ17 - start: data falls while clock high
// RQ18 - watch for start except during write cycle
// RQ19 - stop: data rises while clock high
// RQ20 - stop after read nack returns standby
// RQ21 - stop after write starts internal cycle
// RQ22 - device is only ever a slave
// RQ23 - match acks, mismatch releases to standby
// RQ24 - sample data on clock rising edge
// RQ25 - after lock never ack protection code
// RQ26 - direction bit one reads, zero writes
// RQ27 - release data line when not driving
package eep_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] TYPE_MEM = 4'hA;
   localparam logic [3:0] TYPE_PROT = 4'h6;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [ADDR_W-1:0] LOWER_TOP = 8'h7F;
   localparam logic [3:0] PAGE_MASK = 4'hF;
   localparam int WRITE_TIME_NS = 5000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [10:0] WRITE_CNT_RESET = 11'h000;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } eep_wr_s;
   typedef struct packed {
      logic scl;
      logic sda;
   } eep_bus_s;
   typedef enum logic [1:0] {
      EEP_CMD_NONE,
      EEP_CMD_SET,
      EEP_CMD_CLEAR,
      EEP_CMD_LOCK
   } eep_cmd_e;
endpackage : eep_pkg

// *** rtl/eep_fifo.sv ***
`timescale 1ns/1ns
module eep_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic push;
   logic pop;
   assign in_ready_o = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr_ff != rd_ptr_ff;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else if (flush_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end
endmodule : eep_fifo

// *** rtl/eep_i2c_slave.sv ***
`timescale 1ns/1ns
module eep_i2c_slave
   import eep_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic por_ok_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic strap_select_bit0_i,
   input wire logic strap_select_bit1_i,
   input wire logic strap_select_bit2_i,
   input wire logic elevated_select_voltage_i,
   input wire logic write_protect_input_i,
   output logic lower_protect_o,
   output logic lower_locked_o,
   output logic write_busy_o
);
   import eep_pkg::*;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_SEL,
      PH_ADDR,
      PH_WDATA,
      PH_RDATA,
      PH_RACK
   } eep_state_e;

   // pins are asynchronous to clk_sys_i
   eep_bus_s bus_m_ff;
   eep_bus_s bus_s_ff;
   eep_bus_s bus_d_ff;
   logic [2:0] strap_m_ff;
   logic [2:0] strap_s_ff;
   logic [1:0] misc_m_ff;
   logic [1:0] misc_s_ff;
   logic por_m_ff;
   logic por_s_ff;

   logic [DATA_W-1:0] mem [MEM_DEPTH];
   eep_state_e state_ff;
   logic [2:0] bit_ff;
   logic [DATA_W-1:0] shift_ff;
   logic ack_slot_ff;
   logic ack_drive_ff;
   logic is_read_ff;
   logic is_prot_ff;
   eep_cmd_e cmd_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic drive_low_ff;
   logic write_armed_ff;
   logic [10:0] wcnt_ff;
   logic set_prot_ff;
   logic lock_ff;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic busy;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   eep_wr_s fifo_in;
   eep_wr_s fifo_out;
   logic push;

   function automatic logic addr_writable(input logic [ADDR_W-1:0] a, input logic wp,
                                          input logic prot);
      return !wp && !(prot && (a <= LOWER_TOP)); // [RQ10] [RQ11] [RQ2]
   endfunction : addr_writable

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_m_ff <= '{scl: 1'b1, sda: 1'b1};
         bus_s_ff <= '{scl: 1'b1, sda: 1'b1};
         bus_d_ff <= '{scl: 1'b1, sda: 1'b1};
         strap_m_ff <= 3'h0;
         strap_s_ff <= 3'h0;
         misc_m_ff <= 2'h0;
         misc_s_ff <= 2'h0;
         por_m_ff <= 1'b0;
         por_s_ff <= 1'b0;
      end else begin
         bus_m_ff <= '{scl: scl_i, sda: sda_i};
         bus_s_ff <= bus_m_ff;
         bus_d_ff <= bus_s_ff;
         // floating straps arrive as zero from the pad pull-downs [RQ5]
         strap_m_ff <= {strap_select_bit2_i, strap_select_bit1_i, strap_select_bit0_i};
         strap_s_ff <= strap_m_ff;
         misc_m_ff <= {elevated_select_voltage_i, write_protect_input_i};
         misc_s_ff <= misc_m_ff;
         por_m_ff <= por_ok_i;
         por_s_ff <= por_m_ff;
      end
   end

   assign scl_rise = bus_s_ff.scl && !bus_d_ff.scl; // [RQ24]
   assign scl_fall = !bus_s_ff.scl && bus_d_ff.scl;
   assign start_det = bus_s_ff.scl && bus_d_ff.scl && !bus_s_ff.sda && bus_d_ff.sda; // [RQ17]
   assign stop_det = bus_s_ff.scl && bus_d_ff.scl && bus_s_ff.sda && !bus_d_ff.sda; // [RQ19]
   assign busy = wcnt_ff != WRITE_CNT_RESET;

   // bit engine: the device never makes the clock, only follows it [RQ22]
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= PH_IDLE;
         bit_ff <= 3'h0;
         shift_ff <= 8'h00;
         ack_slot_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         is_read_ff <= 1'b0;
         is_prot_ff <= 1'b0;
         cmd_ff <= EEP_CMD_NONE;
         addr_ff <= 8'h00;
         rdata_ff <= 8'h00;
         drive_low_ff <= 1'b0;
         write_armed_ff <= 1'b0;
      end else if (!por_s_ff || busy) begin
         // supply loss or internal write: bus is ignored entirely [RQ14] [RQ15] [RQ18]
         state_ff <= PH_IDLE;
         drive_low_ff <= 1'b0;
         ack_slot_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         write_armed_ff <= 1'b0;
      end else if (start_det) begin
         // an unmatched select leaves slot flags behind; a start wipes them
         state_ff <= PH_SEL;
         bit_ff <= 3'h0;
         ack_slot_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         drive_low_ff <= 1'b0;
         write_armed_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= PH_IDLE; // [RQ20]
         drive_low_ff <= 1'b0;
         ack_slot_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         write_armed_ff <= 1'b0;
      end else if (state_ff != PH_IDLE) begin
         if (scl_rise && !ack_slot_ff) begin
            shift_ff <= {shift_ff[6:0], bus_s_ff.sda}; // msb first [RQ9]
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == BIT_LAST) begin
               ack_slot_ff <= 1'b1;
            end
            // the stop's own clock rise is bit 0; any later rise disarms the write
            if (bit_ff != 3'h0) begin
               write_armed_ff <= 1'b0; // [RQ21]
            end
         end else if (scl_rise && ack_slot_ff && state_ff == PH_RACK) begin
            // master nack ends reading and idles without waiting for the stop [RQ12] [RQ13]
            if (bus_s_ff.sda) begin
               state_ff <= PH_IDLE;
            end else begin
               state_ff <= PH_RDATA;
               addr_ff <= addr_ff + 8'h01;
               rdata_ff <= mem[addr_ff + 8'h01];
            end
            ack_slot_ff <= 1'b0;
         end else if (scl_fall && ack_slot_ff && !ack_drive_ff && state_ff != PH_RDATA) begin
            ack_drive_ff <= 1'b1;
            write_armed_ff <= 1'b0;
            case (state_ff)
               PH_SEL: begin
                  is_read_ff <= shift_ff[0]; // [RQ26]
                  if (shift_ff[7:4] == TYPE_MEM && shift_ff[3:1] == strap_s_ff) begin // [RQ3] [RQ4]
                     is_prot_ff <= 1'b0;
                     drive_low_ff <= 1'b1; // [RQ23]
                  end else if (shift_ff[7:4] == TYPE_PROT && !lock_ff) begin // [RQ25]
                     is_prot_ff <= 1'b1;
                     if (misc_s_ff[1] && shift_ff[3:1] == {1'b0, strap_s_ff[1], 1'b1} &&
                         !strap_s_ff[2]) begin // [RQ6] [RQ7]
                        cmd_ff <= strap_s_ff[1] ? EEP_CMD_CLEAR : EEP_CMD_SET;
                        drive_low_ff <= 1'b1;
                     end else if (!misc_s_ff[1] && shift_ff[3:1] == strap_s_ff) begin // [RQ8]
                        cmd_ff <= EEP_CMD_LOCK;
                        drive_low_ff <= 1'b1;
                     end else begin
                        state_ff <= PH_IDLE; // [RQ23]
                     end
                  end else begin
                     state_ff <= PH_IDLE; // [RQ23]
                  end
               end
               PH_ADDR: begin
                  addr_ff <= shift_ff;
                  drive_low_ff <= 1'b1; // [RQ12]
               end
               PH_WDATA: begin
                  // protected data byte gets no acknowledge; a full buffer refuses too
                  if (is_prot_ff) begin
                     drive_low_ff <= !misc_s_ff[0]; // [RQ10]
                  end else begin
                     drive_low_ff <= fifo_in_ready &&
                                     addr_writable(addr_ff, misc_s_ff[0], set_prot_ff || lock_ff);
                  end
               end
               default: begin
                  drive_low_ff <= 1'b0;
               end
            endcase
         end else if (scl_fall && ack_slot_ff && ack_drive_ff) begin
            // ninth slot over: hand the line back [RQ27]
            ack_drive_ff <= 1'b0;
            ack_slot_ff <= 1'b0;
            bit_ff <= 3'h0;
            drive_low_ff <= 1'b0;
            case (state_ff)
               PH_SEL: begin
                  if (is_read_ff) begin
                     state_ff <= PH_RDATA;
                     rdata_ff <= is_prot_ff ? 8'h00 : mem[addr_ff];
                     drive_low_ff <= is_prot_ff ? 1'b1 : !mem[addr_ff][7];
                  end else begin
                     state_ff <= PH_ADDR;
                  end
               end
               PH_ADDR: begin
                  state_ff <= PH_WDATA;
               end
               PH_WDATA: begin
                  write_armed_ff <= drive_low_ff;
                  if (!is_prot_ff) begin
                     addr_ff <= {addr_ff[7:4], (addr_ff[3:0] + 4'h1) & PAGE_MASK};
                  end
               end
               default: begin
                  state_ff <= PH_IDLE;
               end
            endcase
         end else if (state_ff == PH_RDATA && scl_fall && !ack_slot_ff) begin
            // present next read bit while clock is low; bit 7 of a later byte too
            drive_low_ff <= !rdata_ff[3'h7 - bit_ff]; // [RQ16]
         end else if (state_ff == PH_RDATA && scl_fall && ack_slot_ff) begin
            // ninth slot belongs to the master [RQ27]
            drive_low_ff <= 1'b0;
            state_ff <= PH_RACK;
         end
      end
   end

   assign push = state_ff == PH_WDATA && !is_prot_ff && scl_fall && ack_slot_ff &&
                 ack_drive_ff && drive_low_ff;
   assign fifo_in = '{addr: addr_ff, data: shift_ff};

   eep_fifo #(
      .WIDTH($bits(eep_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .flush_i(start_det && !busy),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out)
   );

   // page bytes wait in the fifo; only a stop after an ack commits them [RQ21]
   assign fifo_pop = busy && fifo_out_valid;

   always_ff @(posedge clk_sys_i) begin
      if (fifo_pop) begin
         mem[fifo_out.addr] <= fifo_out.data; // [RQ1]
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wcnt_ff <= WRITE_CNT_RESET;
      end else if (busy) begin
         wcnt_ff <= wcnt_ff - 11'h001;
      end else if (stop_det && write_armed_ff && por_s_ff) begin
         wcnt_ff <= 11'(WRITE_CYCLES); // [RQ21]
      end
   end

   // protection bits are nonvolatile in the real part; reset stands in for shipped state
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         set_prot_ff <= 1'b0;
         lock_ff <= 1'b0;
      end else if (stop_det && write_armed_ff && is_prot_ff && por_s_ff && !busy) begin
         case (cmd_ff)
            EEP_CMD_SET: set_prot_ff <= 1'b1; // [RQ2]
            EEP_CMD_CLEAR: set_prot_ff <= 1'b0;
            EEP_CMD_LOCK: lock_ff <= 1'b1; // [RQ2] [RQ25]
            default: set_prot_ff <= set_prot_ff;
         endcase
      end
   end

   assign sda_o = 1'b0; // [RQ16]
   assign sda_oe_n_o = !drive_low_ff; // [RQ27]
   assign lower_protect_o = set_prot_ff || lock_ff;
   assign lower_locked_o = lock_ff;
   // a full buffer is answered with a nack instead of a busy flag
   assign write_busy_o = busy;
endmodule : eep_i2c_slave

// *** testbench/eep_i2c_slave_properties.sv ***
`timescale 1ns/1ns
module eep_i2c_slave_chk
   import eep_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic por_ok_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic strap_select_bit0_i,
   input wire logic strap_select_bit1_i,
   input wire logic strap_select_bit2_i,
   input wire logic elevated_select_voltage_i,
   input wire logic write_protect_input_i,
   input wire logic lower_protect_o,
   input wire logic lower_locked_o,
   input wire logic write_busy_o
);
   int busy_cnt;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= write_busy_o ? busy_cnt + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence s_busy_start;
      $rose(write_busy_o);
   endsequence
   sequence s_por_lost;
      (!por_ok_i) [*5];
   endsequence
   property p_open_drain; sda_o == 1'b0; endproperty
   property p_por_quiet; s_por_lost |-> sda_oe_n_o; endproperty
   property p_wp_prot; write_protect_input_i [*4] |-> !$rose(lower_protect_o); endproperty
   property p_wp_lock; write_protect_input_i [*4] |-> !$rose(lower_locked_o); endproperty
   property p_lock_sticky; lower_locked_o |=> lower_locked_o; endproperty
   property p_lock_prot; lower_locked_o |-> lower_protect_o; endproperty
   property p_busy_hold; s_busy_start |-> write_busy_o [*8]; endproperty
   // slack of one cycle either way: the count start is fixed by the stop detector
   property p_busy_len;
      $fell(write_busy_o) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1;
   endproperty
   property p_busy_quiet; write_busy_o && $past(write_busy_o) |-> sda_oe_n_o; endproperty
   property p_oe_scl_low; $changed(sda_oe_n_o) && por_ok_i |-> !scl_i; endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   a_por_quiet: assert property (p_por_quiet) else $error("answer without power");
   a_wp_prot: assert property (p_wp_prot) else $error("protect set under wp");
   a_wp_lock: assert property (p_wp_lock) else $error("lock set under wp");
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
   a_lock_prot: assert property (p_lock_prot) else $error("locked not protected");
   a_busy_hold: assert property (p_busy_hold) else $error("busy pulse short");
   a_busy_len: assert property (p_busy_len) else $error("write cycle length");
   a_busy_quiet: assert property (p_busy_quiet) else $error("driven while busy");
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, scl high");
endmodule : eep_i2c_slave_chk

bind eep_i2c_slave eep_i2c_slave_chk chk_u (
   .clk_sys_i(clk_sys_i),
   .resetn_i(resetn_i),
   .por_ok_i(por_ok_i),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o),
   .strap_select_bit0_i(strap_select_bit0_i),
   .strap_select_bit1_i(strap_select_bit1_i),
   .strap_select_bit2_i(strap_select_bit2_i),
   .elevated_select_voltage_i(elevated_select_voltage_i),
   .write_protect_input_i(write_protect_input_i),
   .lower_protect_o(lower_protect_o),
   .lower_locked_o(lower_locked_o),
   .write_busy_o(write_busy_o)
);

// *** testbench/eep_i2c_master.sv ***
`timescale 1ns/1ns
module eep_i2c_master (
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   // clock stands high and data is released between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task bus_start;
      #16 sda_low_o = 1'b0;
      #16 scl_o = 1'b1;
      #16 sda_low_o = 1'b1;
      #16 scl_o = 1'b0;
   endtask : bus_start
   task bus_stop;
      #16 sda_low_o = 1'b1;
      #16 scl_o = 1'b1;
      #16 sda_low_o = 1'b0;
      #32;
   endtask : bus_stop
   // data moves only mid-low, sampled mid-high: 64 ns bit period
   task xfer_bit(input logic b, output logic r);
      #16 sda_low_o = ~b;
      #16 scl_o = 1'b1;
      #16 r = sda_i;
      #16 scl_o = 1'b0;
   endtask : xfer_bit
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask : wbyte
   task rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
      xfer_bit(~ack, r);
   endtask : rbyte
endmodule : eep_i2c_master

// *** testbench/eep_i2c_slave_tb.sv ***
`timescale 1ns/1ns
module eep_i2c_slave_tb;
   import eep_pkg::*;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic por_ok_i = 1'b0;
   logic sb0 = 1'b0, sb1 = 1'b0, sb2 = 1'b0, elev = 1'b0, wp = 1'b0;
   logic scl, m_low, sda_o, sda_oe_n_o, prot, lock, busy;
   wire logic sda_w;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   assign sda_w = (m_low || !sda_oe_n_o) ? 1'b0 : 1'b1;
   always #2 clk_sys_i = ~clk_sys_i;
   eep_i2c_master m_u (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_w));
   eep_i2c_slave dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .por_ok_i(por_ok_i),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .strap_select_bit0_i(sb0), .strap_select_bit1_i(sb1), .strap_select_bit2_i(sb2),
      .elevated_select_voltage_i(elev), .write_protect_input_i(wp),
      .lower_protect_o(prot), .lower_locked_o(lock), .write_busy_o(busy));
   task stop_test;
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // acks of select, address, data; m masks slots whose answer is left open
   task cmd_wr(input logic [7:0] sel, a, d, input logic [2:0] m, e);
      logic [2:0] ak;
      m_u.bus_start();
      m_u.wbyte(sel, ak[2]);
      m_u.wbyte(a, ak[1]);
      m_u.wbyte(d, ak[0]);
      m_u.bus_stop();
      chk({5'h00, ak & m}, {5'h00, e});
   endtask : cmd_wr
   task rd(input logic [7:0] sel, a, e);
      logic [7:0] d;
      logic k;
      m_u.bus_start();
      m_u.wbyte(sel, k);
      m_u.wbyte(a, k);
      m_u.bus_start();
      m_u.wbyte(sel | 8'h01, k);
      m_u.rbyte(1'b0, d);
      m_u.bus_stop();
      chk(d, e);
   endtask : rd
   task wait_idle;
      for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask : wait_idle
   // pins go through synchronisers, so give them a few cycles to land
   task pins(input logic ev, b2, b1, b0, w);
      @(negedge clk_sys_i);
      elev = ev;
      sb2 = b2;
      sb1 = b1;
      sb0 = b0;
      wp = w;
      repeat (6) @(negedge clk_sys_i);
   endtask : pins
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      cmd_wr(8'hA0, 8'h10, 8'h5A, 3'h7, 3'h0);
      por_ok_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      cmd_wr(8'hA0, 8'h10, 8'h5A, 3'h7, 3'h7);
      chk({7'h00, busy}, 8'h01);
      cmd_wr(8'hA0, 8'h11, 8'h00, 3'h4, 3'h0);
      wait_idle();
      rd(8'hA0, 8'h10, 8'h5A);
      cmd_wr(8'hA2, 8'h10, 8'h00, 3'h7, 3'h0);
      cmd_wr(8'hE0, 8'h10, 8'h00, 3'h7, 3'h0);
      rd(8'hA0, 8'h10, 8'h5A);
      cmd_wr(8'hA0, 8'h20, 8'h33, 3'h7, 3'h7);
      wait_idle();
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      cmd_wr(8'hA0, 8'h20, 8'h11, 3'h7, 3'h6);
      wait_idle();
      rd(8'hA0, 8'h20, 8'h33);
      pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      cmd_wr(8'h62, 8'h00, 8'h00, 3'h7, 3'h6);
      wait_idle();
      chk({7'h00, prot}, 8'h00);
      pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      cmd_wr(8'h62, 8'h00, 8'h00, 3'h7, 3'h7);
      wait_idle();
      chk({7'h00, prot}, 8'h01);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      cmd_wr(8'hA0, 8'h20, 8'h44, 3'h7, 3'h6);
      cmd_wr(8'hA0, 8'h90, 8'h77, 3'h7, 3'h7);
      wait_idle();
      rd(8'hA0, 8'h90, 8'h77);
      rd(8'hA0, 8'h20, 8'h33);
      cmd_wr(8'h66, 8'h00, 8'h00, 3'h4, 3'h0);
      pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      cmd_wr(8'h66, 8'h00, 8'h00, 3'h7, 3'h7);
      wait_idle();
      chk({7'h00, prot}, 8'h00);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      cmd_wr(8'h60, 8'h00, 8'h00, 3'h7, 3'h7);
      wait_idle();
      chk({6'h00, lock, prot}, 8'h03);
      pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      cmd_wr(8'h66, 8'h00, 8'h00, 3'h4, 3'h0);
      wait_idle();
      chk({6'h00, lock, prot}, 8'h03);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      por_ok_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      cmd_wr(8'hA0, 8'hA0, 8'h00, 3'h7, 3'h0);
      stop_test();
   end
endmodule : eep_i2c_slave_tb
